/* File: hdl/stp_pkg.sv */
// constants shared by the timer prescaler and its pin edge logic
package stp_pkg;
	localparam int unsigned ADDR_W = 12;
	localparam int unsigned DATA_W = 32;
	// printed offsets are word indices; byte address is four times
	localparam logic [7:0] GTC_IDX = 8'h23;
	localparam logic [7:0] SEL0_IDX = 8'h24;
	localparam logic [7:0] SEL1_IDX = 8'h25;
	localparam logic [7:0] CNT_IDX = 8'h26;
	localparam logic [ADDR_W-1:0] GTC_ADDR = {2'h0, GTC_IDX, 2'h0};
	localparam logic [ADDR_W-1:0] SEL0_ADDR = {2'h0, SEL0_IDX, 2'h0};
	localparam logic [ADDR_W-1:0] SEL1_ADDR = {2'h0, SEL1_IDX, 2'h0};
	localparam logic [ADDR_W-1:0] CNT_ADDR = {2'h0, CNT_IDX, 2'h0};
	localparam int unsigned HOLD_BIT = 7;
	localparam int unsigned ASY_BIT = 1;
	localparam int unsigned SYN_BIT = 0;
	localparam logic [7:0] GTC_RESET = 8'h00;
	localparam logic [2:0] SEL_RESET = 3'h0;
	localparam int unsigned PRE_WIDTH = 10;
	localparam int unsigned DIV8_BITS = 3;
	localparam int unsigned DIV64_BITS = 6;
	localparam int unsigned DIV256_BITS = 8;
	localparam int unsigned DIV1024_BITS = 10;
	typedef enum logic [2:0] {
		CS_STOP = 3'h0,
		CS_DIV1 = 3'h1,
		CS_DIV8 = 3'h2,
		CS_DIV64 = 3'h3,
		CS_DIV256 = 3'h4,
		CS_DIV1024 = 3'h5,
		CS_EXT_FALL = 3'h6,
		CS_EXT_RISE = 3'h7
	} stp_csel_type;
endpackage

/* File: hdl/stp_pin_edge.sv */
// external count pin synchroniser and edge detector
`timescale 1ns/1ps
`default_nettype none
module stp_pin_edge
	import stp_pkg::*;
(
	input wire logic pclk,
	input wire logic presetn,
	input wire logic count_pin,
	output logic rise,
	output logic fall
);
	typedef struct packed {
		logic sync;
		logic prev;
	} stp_edge_type;

	logic half_q;
	stp_edge_type s_reg;
	stp_edge_type s_next;

	// falling-edge stage acts as the latch open while the clock is high
	always_ff @(negedge pclk or negedge presetn) begin
		if (!presetn) begin
			half_q <= 1'b0;
		end else begin
			half_q <= count_pin;
		end
	end

	always_comb begin
		s_next = s_reg;
		s_next.sync = half_q;
		s_next.prev = s_reg.sync;
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			s_reg <= '0;
		end else begin
			s_reg <= s_next;
		end
	end

	// edges are decoded from settled stages only; the owner registers them
	assign rise = s_reg.sync & ~s_reg.prev;
	assign fall = ~s_reg.sync & s_reg.prev;

	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);

	chk_one_rise_tick: assert property (rise |=> !rise)
		else $error("rise edge held longer than one cycle");
	chk_fall_follows: assert property ($fell(s_reg.sync) |-> fall)
		else $error("falling edge not reported");
endmodule // stp_pin_edge
`default_nettype wire

/* File: hdl/stp_top.sv */
// shared timer prescaler with external count inputs and apb registers
//
// The APB register port was decided locally.
`timescale 1ns/1ps
`default_nettype none
module stp_top
	import stp_pkg::*;
#(
	parameter int unsigned TIMERS = 2
) (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [ADDR_W-1:0] paddr,
	input wire logic [DATA_W-1:0] pwdata,
	output logic [DATA_W-1:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic [TIMERS-1:0] external_count_pin,
	output logic [TIMERS-1:0] timer_count_tick,
	output logic sync_hold_mode,
	output logic async_prescaler_reset,
	output logic sync_prescaler_reset
);
	typedef struct packed {
		logic hold;
		logic asy;
		logic syn;
		logic [TIMERS-1:0][2:0] sel;
		logic [PRE_WIDTH-1:0] cnt;
		logic [TIMERS-1:0] tick;
		logic [DATA_W-1:0] rdata;
		logic err;
	} stp_state_type;

	stp_state_type s_reg;
	stp_state_type s_next;
	logic [TIMERS-1:0] rise;
	logic [TIMERS-1:0] fall;
	logic [3:0] tap;
	logic setup;
	logic access;
	logic hit_gtc;
	logic hit_sel0;
	logic hit_sel1;
	logic hit_cnt;
	logic hit_any;
	logic gtc_wr;
	logic [7:0] gtc_view;

	genvar gi;
	generate
		for (gi = 0; gi < TIMERS; gi++) begin : g_pin
			stp_pin_edge u_edge (
				.pclk(pclk),
				.presetn(presetn),
				.count_pin(external_count_pin[gi]),
				.rise(rise[gi]),
				.fall(fall[gi])
			);
		end
	endgenerate

	assign setup = psel & ~penable;
	assign access = psel & penable;
	assign hit_gtc = paddr == GTC_ADDR;
	assign hit_sel0 = paddr == SEL0_ADDR;
	assign hit_sel1 = paddr == SEL1_ADDR;
	assign hit_cnt = paddr == CNT_ADDR;
	assign hit_any = hit_gtc | hit_sel0 | hit_sel1 | hit_cnt;
	assign gtc_wr = access & pwrite & hit_gtc;

	// reserved bits 6..2 are tied low in the view
	always_comb begin
		gtc_view = GTC_RESET;
		gtc_view[HOLD_BIT] = s_reg.hold;
		gtc_view[ASY_BIT] = s_reg.asy;
		gtc_view[SYN_BIT] = s_reg.syn;
	end

	// one-cycle enables; none while the divider is held in reset
	always_comb begin
		tap[0] = ~s_reg.syn & (&s_reg.cnt[DIV8_BITS-1:0]);
		tap[1] = ~s_reg.syn & (&s_reg.cnt[DIV64_BITS-1:0]);
		tap[2] = ~s_reg.syn & (&s_reg.cnt[DIV256_BITS-1:0]);
		tap[3] = ~s_reg.syn & (&s_reg.cnt[DIV1024_BITS-1:0]);
	end

	always_comb begin
		s_next = s_reg;

		// divider never looks at any select, so picking a tap
		// does not realign it
		if (s_reg.syn) begin
			s_next.cnt = '0;
		end else begin
			s_next.cnt = PRE_WIDTH'(s_reg.cnt + 1'b1);
		end

		// every timer taps the same divider through its own select
		for (int t = 0; t < TIMERS; t++) begin
			case (s_reg.sel[t])
				CS_STOP: begin
					s_next.tick[t] = 1'b0;
				end
				CS_DIV1: begin
					s_next.tick[t] = 1'b1;
				end
				CS_DIV8: begin
					s_next.tick[t] = tap[0];
				end
				CS_DIV64: begin
					s_next.tick[t] = tap[1];
				end
				CS_DIV256: begin
					s_next.tick[t] = tap[2];
				end
				CS_DIV1024: begin
					s_next.tick[t] = tap[3];
				end
				CS_EXT_FALL: begin
					s_next.tick[t] = fall[t];
				end
				CS_EXT_RISE: begin
					s_next.tick[t] = rise[t];
				end
				default: begin
					s_next.tick[t] = 1'b0;
				end
			endcase
		end

		// a software write beats the hardware self-clear
		if (gtc_wr) begin
			s_next.hold = pwdata[HOLD_BIT];
			s_next.asy = pwdata[ASY_BIT];
			s_next.syn = pwdata[SYN_BIT];
		end else if (!s_reg.hold) begin
			s_next.asy = 1'b0;
			s_next.syn = 1'b0;
		end

		if (access && pwrite && hit_sel0) begin
			s_next.sel[0] = pwdata[2:0];
		end
		if (access && pwrite && hit_sel1) begin
			s_next.sel[1] = pwdata[2:0];
		end

		// read data is captured in the setup cycle so the access
		// phase can complete with no wait state
		if (setup) begin
			s_next.err = ~hit_any;
			if (hit_gtc) begin
				s_next.rdata = {24'h000000, gtc_view};
			end else if (hit_sel0) begin
				s_next.rdata = {29'h00000000, s_reg.sel[0]};
			end else if (hit_sel1) begin
				s_next.rdata = {29'h00000000, s_reg.sel[1]};
			end else if (hit_cnt) begin
				s_next.rdata = {22'h000000, s_reg.cnt};
			end else begin
				s_next.rdata = '0;
			end
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			s_reg <= '0;
		end else begin
			s_reg <= s_next;
		end
	end

	assign prdata = s_reg.rdata;
	assign pready = 1'b1;
	assign pslverr = access & s_reg.err;
	assign timer_count_tick = s_reg.tick;
	assign sync_hold_mode = s_reg.hold;
	assign async_prescaler_reset = s_reg.asy;
	assign sync_prescaler_reset = s_reg.syn;

	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);

	sequence seq_sel_div8;
		$changed(s_reg.sel[0]) && s_reg.sel[0] == CS_DIV8;
	endsequence

	sequence seq_gap8;
		(!tap[0])[*7] ##1 tap[0];
	endsequence

	sequence seq_release;
		gtc_wr && pwdata[7:0] == GTC_RESET;
	endsequence

	chk_direct_tick: assert property (
		s_reg.sel[0] == CS_DIV1 |=> s_reg.tick[0])
		else $error("select one did not tick");

	chk_tap8_period: assert property (
		@(posedge pclk) disable iff (!presetn || s_reg.syn)
		tap[0] |=> seq_gap8)
		else $error("divide by 8 tap period wrong");

	chk_shared_taps: assert property (
		s_reg.sel[0] == s_reg.sel[1]
		&& s_reg.sel[0] inside {CS_DIV8, CS_DIV64, CS_DIV256, CS_DIV1024}
		|=> s_reg.tick[0] == s_reg.tick[1])
		else $error("timers on one tap disagree");

	chk_free_divider: assert property (
		!s_reg.syn |=> s_reg.cnt == PRE_WIDTH'($past(s_reg.cnt) + 1'b1))
		else $error("divider did not advance");

	chk_first_count: assert property (
		@(posedge pclk) disable iff (!presetn || s_reg.syn)
		seq_sel_div8 |-> ##[1:9] s_reg.tick[0])
		else $error("first divided tick too late");

	// select one and pin modes keep ticking through a prescaler reset
	chk_presc_clear: assert property (
		s_reg.syn |=> s_reg.cnt == '0 && (!s_reg.tick[1]
		|| $past(s_reg.sel[1]) inside {CS_DIV1, CS_EXT_FALL, CS_EXT_RISE}))
		else $error("prescaler reset did not restart divider");

	chk_ext_rise: assert property (
		s_reg.sel[0] == CS_EXT_RISE |=> s_reg.tick[0] == $past(rise[0]))
		else $error("rising edge tick mismatch");

	chk_ext_no_div: assert property (
		s_reg.syn && s_reg.sel[1] == CS_EXT_FALL && fall[1]
		|=> s_reg.tick[1])
		else $error("pin tick blocked by prescaler reset");

	chk_hold_keeps: assert property (
		s_reg.hold && !gtc_wr |=> $stable(s_reg.syn) && $stable(s_reg.asy))
		else $error("held reset bits changed");

	chk_hold_release: assert property (
		seq_release |=> !s_reg.syn && !s_reg.asy && !s_reg.hold)
		else $error("reset bits not cleared on release");

	chk_self_clear: assert property (
		s_reg.syn && !s_reg.hold && !gtc_wr |=> !s_reg.syn)
		else $error("sync reset bit did not self-clear");

	chk_reserved_zero: assert property (
		setup && hit_gtc |=> prdata[31:8] == '0 && prdata[6:2] == '0)
		else $error("reserved control bits read nonzero");

	chk_stop_silent: assert property (
		(s_reg.sel[0] == CS_STOP) [*2] |=> !s_reg.tick[0])
		else $error("stopped timer ticked");
endmodule // stp_top
`default_nettype wire

/* File: verif/stp_pin_model.sv */
// partner model: drives the external count pins
`timescale 1ns/1ps
`default_nettype none
module stp_pin_model #(
	parameter int HALF = 3
) (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic run,
	output logic [1:0] pin
);
	int cnt;
	// phases of HALF cycles keep the rate below clock / 2.5
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			cnt <= 0;
			pin <= 2'h0;
		end else if (run) begin // level frozen while idle
			cnt <= (cnt == HALF - 1) ? 0 : cnt + 1;
			if (cnt == HALF - 1) pin <= ~pin;
		end
	end
endmodule // stp_pin_model
`default_nettype wire

/* File: verif/stp_top_tb.sv */
// self-checking bench for the shared timer prescaler
`timescale 1ns/1ps
`default_nettype none
module stp_top_tb
	import stp_pkg::*;
;
	logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0;
	logic pwrite = 1'b0, run = 1'b0, pready, pslverr, er, hold_o, asy_o, syn_o;
	logic [ADDR_W-1:0] paddr = '0;
	logic [DATA_W-1:0] pwdata = '0, prdata, rd;
	logic [1:0] pin, tick, pin_q = 2'h0;
	int n_errors = 0, num_checks = 0, cyc = 0, t0 = 0, t1 = 0;
	int rises = 0, falls = 0, k, a, b, f0;
	int divs[4] = '{8, 64, 256, 1024};
	always #50 pclk = ~pclk;
	stp_top #(.TIMERS(2)) stp_top_i (.pclk(pclk), .presetn(presetn),
		.psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
		.pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
		.external_count_pin(pin), .timer_count_tick(tick),
		.sync_hold_mode(hold_o), .async_prescaler_reset(asy_o),
		.sync_prescaler_reset(syn_o));
	stp_pin_model stp_pin_model_i (.pclk(pclk), .presetn(presetn), .run(run),
		.pin(pin));
	// counting on the falling edge keeps clear of register updates
	always @(negedge pclk) begin
		cyc++;
		if (tick[0] === 1'b1) t0++;
		if (tick[1] === 1'b1) t1++;
		if (pin[0] && !pin_q[0]) rises++;
		if (!pin[0] && pin_q[0]) falls++;
		pin_q = pin;
		if (cyc == 40000) begin
			n_errors++;
			test_done;
		end
	end
	task test_done;
		$display("checks %0d errors %0d", num_checks, n_errors);
		if (n_errors == 0 && num_checks > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask
	task cmp(input string nm, input logic [31:0] exp, input logic [31:0] got);
		num_checks++;
		if (got !== exp) begin
			n_errors++;
			$display("[FAIL] %s expected %h seen %h", nm, exp, got);
		end
	endtask
	task apb(input logic w, input logic [ADDR_W-1:0] ad, input logic [31:0] d);
		logic rdy;
		@(posedge pclk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= ad;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		// answer is taken at the rising edge that completes the access
		do begin
			@(posedge pclk);
			rdy = pready;
			rd = prdata;
			er = pslverr;
		end while (rdy !== 1'b1);
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	task rdchk(input string nm, input logic [ADDR_W-1:0] ad,
		input logic [31:0] e);
		apb(1'b0, ad, 32'h0);
		cmp(nm, e, rd);
	endtask
	task win(input int n);
		int s0, s1;
		@(posedge pclk);
		s0 = t0;
		s1 = t1;
		repeat (n) @(posedge pclk);
		a = t0 - s0;
		b = t1 - s1;
	endtask
	// the tick of the first cycle still belongs to the old select, or to the divider before its reset
	task first(input int t);
		k = 0;
		do begin
			@(negedge pclk);
			k++;
		end while (!(tick[t] === 1'b1 && k > 1) && k < 2000);
	endtask
	initial begin
		repeat (5) @(posedge pclk);
		presetn <= 1'b1;
		rdchk("ctrl reset", GTC_ADDR, 32'h0);
		rdchk("sel0 reset", SEL0_ADDR, 32'h0);
		apb(1'b0, 12'h000, 32'h0);
		cmp("unmapped err", 32'h1, {31'h0, er});
		cmp("pready", 32'h1, {31'h0, pready});
		win(64);
		cmp("stopped ticks", 32'h0, a);
		apb(1'b1, SEL0_ADDR, 32'h1);
		win(16);
		cmp("div1 ticks", 32'h10, a);
		apb(1'b1, SEL0_ADDR, 32'h2);
		apb(1'b1, GTC_ADDR, 32'hFF);
		rdchk("ctrl held", GTC_ADDR, 32'h83);
		cmp("sync reset out", 32'h1, {31'h0, syn_o});
		cmp("hold out", 32'h1, {31'h0, hold_o});
		cmp("async reset out", 32'h1, {31'h0, asy_o});
		rdchk("divider held", CNT_ADDR, 32'h0);
		win(32);
		cmp("held ticks", 32'h0, a);
		apb(1'b1, GTC_ADDR, 32'h0);
		rdchk("ctrl released", GTC_ADDR, 32'h0);
		apb(1'b1, GTC_ADDR, 32'h1);
		rdchk("ctrl selfclear", GTC_ADDR, 32'h0);
		for (int i = 0; i < 4; i++) begin
			apb(1'b1, SEL0_ADDR, 32'(2 + i));
			first(0);
			cmp("first tick", 32'h1, {31'h0, k <= divs[i] + 1});
			apb(1'b1, SEL1_ADDR, 32'(2 + (i + 1) % 4));
			apb(1'b1, GTC_ADDR, 32'h1);
			first(1);
			f0 = divs[(i + 1) % 4];
			cmp("restart", 32'h1, {31'h0, k >= f0 - 2 && k <= f0 + 2});
			win(2048);
			cmp("tap0 ticks", 32'(2048 / divs[i]), a);
			cmp("tap1 ticks", 32'(2048 / f0), b);
		end
		apb(1'b1, SEL0_ADDR, 32'h7); // pin idle and stable here
		apb(1'b1, SEL1_ADDR, 32'h6);
		// prescaler held in reset while the pins count
		apb(1'b1, GTC_ADDR, 32'h81);
		@(posedge pclk);
		a = t0;
		b = t1;
		k = rises;
		f0 = falls;
		run <= 1'b1;
		repeat (60) @(posedge pclk);
		run <= 1'b0;
		repeat (8) @(posedge pclk);
		apb(1'b1, GTC_ADDR, 32'h0);
		cmp("rise ticks", 32'(rises - k), 32'(t0 - a));
		cmp("fall ticks", 32'(falls - f0), 32'(t1 - b));
		cmp("pin edges seen", 32'h1, {31'h0, rises - k > 5});
		test_done;
	end
endmodule // stp_top_tb
`default_nettype wire
